// ### src/touch_link.sv
// What this block does
// - sensor speaks only after a host command
// - strap high or open: slave-only, low: master-slave
// - host shifts on falling, sensor samples rising
// - ready line low only when answer waits
// - load byte, assert ready, release after collection
// - next ready only after select returns high
// - bad command gives no ready; host times out
// - setup write delay grows with key count
// - typical delays: lock, calibrate, ordinary commands
// - master-slave: sensor drives select, clock, byte
// - sensor master changes data on falling edges
// - shared data line, driven from the first answer byte through the last, gaps included
// - sensor reverts to slave after the exchange
// - answer bytes spaced 15us to 2ms apart
// - data-less commands answered by command echo
`include "touch_link_defines.svh"

module touch_link
    import touch_link_pkg::*;
#(
    parameter int HALF_SCK = (`CLK_MHZ * 1000 + 2 * `SCK_MAX_KHZ - 1) / (2 * `SCK_MAX_KHZ),
    parameter int T_OTHER = `DLY_OTHER_US * `CLK_MHZ,
    parameter int T_CAL = `DLY_CAL_US * `CLK_MHZ,
    parameter int T_ONE = `DLY_ONE_KEY_US * `CLK_MHZ,
    parameter int T_EIGHT = `DLY_EIGHT_KEY_US * `CLK_MHZ,
    parameter int T_ALL = `DLY_ALL_KEY_US * `CLK_MHZ,
    parameter int T_LOCK = `DLY_LOCK_US * `CLK_MHZ,
    parameter int T_SPACE_MAX = `SPACING_MAX_US * `CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic sck_i,
    input wire logic ss_n_i,
    input wire logic mosi_i,
    input wire logic topology_select_i,
    input wire answer_t answer_i,
    input wire logic answer_valid_i,
    input wire delay_req_t delay_req_i,
    output logic cmd_valid_o,
    output logic [7:0] cmd_byte_o,
    output logic answer_ready_o,
    output logic answer_late_o,
    output logic master_mode_o,
    output logic drdy_n_o,
    output logic miso_o,
    output logic sck_o,
    output logic sck_oe_o,
    output logic mosi_o,
    output logic mosi_oe_o,
    output logic ss_n_o,
    output logic ss_n_oe_o
);

localparam int SPACE_MIN = `SPACING_MIN_US * `CLK_MHZ;

link_state_t state;
logic [7:0] rx_byte;
logic rx_toggle;
logic [2:0] sync_out;
logic ss_high;
logic rx_tog_s;
logic topo_s;
logic rx_tog_d;
logic rx_evt;
logic [1:0] strap_cnt;
logic strap_done;
logic [7:0] tx_byte;
logic [7:0] tx_sh;
logic last_q;
logic [2:0] bit_cnt;
logic [7:0] echo_byte;
logic first_q;
logic accept;
logic new_cmd;
logic [15:0] half_cnt;
logic half_done;
logic in_master;
logic [15:0] gap_cnt;
logic gap_done;
logic [31:0] resp_cnt;
logic [31:0] limit;

////////////////////////////////////////////////////////////////////////////
// link domain and crossings
touch_link_shift u_shift (
    .sck_i(sck_i),
    .ss_n_i(ss_n_i),
    .reset_i(reset_i),
    .mosi_i(mosi_i),
    .tx_byte_i(tx_byte),
    .rx_byte_o(rx_byte),
    .rx_toggle_o(rx_toggle),
    .miso_o(miso_o)
);

touch_sync #(.W(3)) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i({ss_n_i, rx_toggle, topology_select_i}),
    .q_o(sync_out)
);

assign ss_high = sync_out[2];
assign rx_tog_s = sync_out[1];
assign topo_s = sync_out[0];
assign rx_evt = rx_tog_s ^ rx_tog_d;
assign accept = answer_valid_i && answer_ready_o;
// a late answer lets the host retry with a fresh command
assign new_cmd = strap_done && rx_evt
    && (state == ST_IDLE || (state == ST_WAIT && answer_late_o));
assign in_master = state inside {ST_M_SEL, ST_M_HIGH, ST_M_LOW, ST_M_END, ST_M_REL};
assign half_done = half_cnt == 16'(HALF_SCK - 1);
assign gap_done = gap_cnt == 16'(SPACE_MIN - 1);

always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
        rx_tog_d <= 1'b0;
    end else begin
        rx_tog_d <= rx_tog_s;
    end
end

////////////////////////////////////////////////////////////////////////////
// strap caught once after release, never again
always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
        strap_cnt <= 2'h0;
        strap_done <= 1'b0;
        master_mode_o <= 1'b0;
    end else if (!strap_done) begin
        strap_cnt <= strap_cnt + 2'h1;
        if (strap_cnt == `STRAP_WAIT) begin
            strap_done <= 1'b1;
            master_mode_o <= ~topo_s;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// received bytes go to the command decoder
always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
        cmd_valid_o <= 1'b0;
        cmd_byte_o <= 8'h00;
    end else begin
        cmd_valid_o <= strap_done && rx_evt && state inside {ST_IDLE, ST_WAIT};
        if (strap_done && rx_evt && state inside {ST_IDLE, ST_WAIT}) begin
            cmd_byte_o <= rx_byte;
        end
    end
end

// echo keeps the command byte, not a following operand
always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
        echo_byte <= 8'h00;
        first_q <= 1'b0;
    end else if (new_cmd) begin
        echo_byte <= rx_byte;
        first_q <= 1'b1;
    end else if (accept) begin
        first_q <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////
// timers
always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
        half_cnt <= 16'h0000;
    end else if (!in_master || half_done) begin
        half_cnt <= 16'h0000;
    end else begin
        half_cnt <= half_cnt + 16'h0001;
    end
end

always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
        gap_cnt <= 16'h0000;
    end else if (state == ST_GAP) begin
        gap_cnt <= gap_cnt + 16'h0001;
    end else begin
        gap_cnt <= 16'h0000;
    end
end

// deadline: command class for the first byte, spacing for the rest
always_comb begin
    limit = 32'(T_SPACE_MAX);
    if (first_q) begin
        case (delay_req_i.cls)
            CLS_OTHER: limit = 32'(T_OTHER);
            CLS_CAL: limit = 32'(T_CAL);
            CLS_LOCK: limit = 32'(T_LOCK);
            CLS_SETUP: begin
                if (delay_req_i.keys <= `KEYS_ONE) begin
                    limit = 32'(T_ONE);
                end else if (delay_req_i.keys <= `KEYS_EIGHT) begin
                    limit = 32'(T_EIGHT);
                end else begin
                    limit = 32'(T_ALL);
                end
            end
            default: limit = 32'(T_OTHER);
        endcase
    end
end

// late only flags; ready still waits for a real answer
always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
        resp_cnt <= 32'h00000000;
        answer_late_o <= 1'b0;
    end else if (new_cmd || accept) begin
        resp_cnt <= 32'h00000000;
        answer_late_o <= 1'b0;
    end else if (state inside {ST_WAIT, ST_GAP}) begin
        if (resp_cnt >= limit) begin
            answer_late_o <= 1'b1;
        end else begin
            resp_cnt <= resp_cnt + 32'h00000001;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// answer sequencer; even at HALF_SCK of 1 an own byte reaches rx_evt in ST_M_REL or ST_GAP, not as a command
always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
        state <= ST_IDLE;
        answer_ready_o <= 1'b0;
        drdy_n_o <= 1'b1;
        tx_byte <= 8'h00;
        tx_sh <= 8'h00;
        last_q <= 1'b0;
        bit_cnt <= 3'h0;
        sck_o <= 1'b0;
        sck_oe_o <= 1'b0;
        mosi_o <= 1'b0;
        mosi_oe_o <= 1'b0;
        ss_n_o <= 1'b1;
        ss_n_oe_o <= 1'b0;
    end else begin
        case (state)
            ST_IDLE: begin
                if (new_cmd) begin
                    state <= ST_WAIT;
                    answer_ready_o <= 1'b1;
                end
            end
            ST_WAIT: begin
                if (accept) begin
                    answer_ready_o <= 1'b0;
                    tx_byte <= answer_i.echo ? echo_byte : answer_i.data;
                    tx_sh <= answer_i.echo ? echo_byte : answer_i.data;
                    last_q <= answer_i.last;
                    if (master_mode_o) begin
                        state <= ST_M_SEL;
                        sck_o <= 1'b0;
                        sck_oe_o <= 1'b1;
                        ss_n_o <= 1'b0;
                        ss_n_oe_o <= 1'b1;
                        mosi_o <= answer_i.echo ? echo_byte[7] : answer_i.data[7];
                        mosi_oe_o <= 1'b1;
                        bit_cnt <= 3'h0;
                    end else begin
                        state <= ST_READY;
                        drdy_n_o <= 1'b0;
                    end
                end
            end
            ST_READY: begin
                if (rx_evt) begin
                    drdy_n_o <= 1'b1;
                    state <= ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (ss_high) begin
                    state <= last_q ? ST_IDLE : ST_GAP;
                end
            end
            ST_GAP: begin
                if (gap_done) begin
                    state <= ST_WAIT;
                    answer_ready_o <= 1'b1;
                end
            end
            ST_M_SEL: begin
                if (half_done) begin
                    sck_o <= 1'b1;
                    state <= ST_M_HIGH;
                end
            end
            ST_M_HIGH: begin
                if (half_done) begin
                    sck_o <= 1'b0;
                    if (bit_cnt == `BIT_LAST) begin
                        state <= ST_M_END;
                    end else begin
                        tx_sh <= {tx_sh[6:0], 1'b0};
                        mosi_o <= tx_sh[6];
                        bit_cnt <= bit_cnt + 3'h1;
                        state <= ST_M_LOW;
                    end
                end
            end
            ST_M_LOW: begin
                if (half_done) begin
                    sck_o <= 1'b1;
                    state <= ST_M_HIGH;
                end
            end
            ST_M_END: begin
                if (half_done) begin
                    ss_n_o <= 1'b1;
                    state <= last_q ? ST_M_REL : ST_GAP;
                end
            end
            ST_M_REL: begin
                if (half_done) begin
                    sck_oe_o <= 1'b0;
                    mosi_oe_o <= 1'b0;
                    ss_n_oe_o <= 1'b0;
                    state <= ST_IDLE;
                end
            end
            default: begin
                state <= ST_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// checks
default clocking cb @(posedge clk_i);
endclocking
default disable iff (reset_i);

a_drdy_needs_cmd: assert property (
    $fell(drdy_n_o) |-> $past(state) == ST_WAIT && !master_mode_o && $past(accept))
    else $error("ready raised without a pending command");

a_strap_held: assert property (
    strap_done && $past(strap_done) |-> $stable(master_mode_o))
    else $error("topology changed after capture");

a_drdy_rests_high: assert property (
    state inside {ST_IDLE, ST_WAIT, ST_HOLD, ST_GAP} |-> drdy_n_o)
    else $error("ready low with no byte loaded");

a_drdy_release: assert property (
    state == ST_READY && rx_evt |=> drdy_n_o && state == ST_HOLD)
    else $error("ready not released after collection");

a_hold_for_ss: assert property (
    state == ST_HOLD && !ss_high |=> state == ST_HOLD && drdy_n_o)
    else $error("next byte signalled before select high");

a_gap_length: assert property (
    $fell(state == ST_GAP) |-> $past(gap_cnt) == 16'(SPACE_MIN - 1))
    else $error("answer bytes spaced too closely");

a_late_quiet: assert property (
    answer_late_o && state == ST_WAIT && !accept |-> drdy_n_o ##1 drdy_n_o)
    else $error("ready asserted for an unanswered command");

a_late_timing: assert property (
    $rose(answer_late_o) |-> $past(resp_cnt) >= $past(limit))
    else $error("late flag before the deadline");

a_slave_quiet: assert property (
    !master_mode_o |-> !sck_oe_o && !mosi_oe_o && !ss_n_oe_o)
    else $error("slave-only mode drives shared lines");

a_ss_sck_low: assert property (
    ss_n_oe_o && $changed(ss_n_o) |-> !sck_o && !$past(sck_o))
    else $error("select moved while clock high");

a_data_on_fall: assert property (
    mosi_oe_o && $past(mosi_oe_o) && $changed(mosi_o) && state != ST_M_SEL
    |-> !sck_o && $past(sck_o))
    else $error("master data changed off a falling edge");

a_echo_byte: assert property (
    accept && answer_i.echo |=> tx_byte == echo_byte)
    else $error("echo differs from command byte");

a_revert_slave: assert property (
    state == ST_M_REL && half_done |=> state == ST_IDLE && !sck_oe_o && !ss_n_oe_o)
    else $error("sensor kept the bus after the exchange");

c_slave_collect: cover property (state == ST_READY && rx_evt);
c_master_byte: cover property (state == ST_M_END && half_done);
c_multi_gap: cover property ($fell(state == ST_GAP));
c_late: cover property ($rose(answer_late_o));

endmodule

// ### pkg/touch_link_defines.svh
`ifndef TOUCH_LINK_DEFINES_SVH
`define TOUCH_LINK_DEFINES_SVH

// core clock and link limits
`define CLK_MHZ 20
`define SCK_MAX_KHZ 1500
`define BIT_LAST 3'h7

// answer byte spacing window, microseconds
`define SPACING_MIN_US 15
`define SPACING_MAX_US 2000

// typical response delays, microseconds
`define DLY_ONE_KEY_US 10000
`define DLY_EIGHT_KEY_US 40000
`define DLY_ALL_KEY_US 300000
`define DLY_LOCK_US 800000
`define DLY_CAL_US 3000
`define DLY_OTHER_US 400

// key counts that pick the setup-write delay
`define KEYS_ONE 7'h01
`define KEYS_EIGHT 7'h08

// cycles after reset release before the strap is caught
`define STRAP_WAIT 2'h3

`endif

// ### pkg/touch_link_pkg.sv
package touch_link_pkg;

typedef enum logic [1:0] {
    CLS_OTHER = 2'b00,
    CLS_CAL = 2'b01,
    CLS_SETUP = 2'b10,
    CLS_LOCK = 2'b11
} delay_class_t;

typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_WAIT = 4'b0001,
    ST_READY = 4'b0010,
    ST_HOLD = 4'b0011,
    ST_GAP = 4'b0100,
    ST_M_SEL = 4'b0101,
    ST_M_HIGH = 4'b0110,
    ST_M_LOW = 4'b0111,
    ST_M_END = 4'b1000,
    ST_M_REL = 4'b1001
} link_state_t;

typedef struct packed {
    logic echo;
    logic last;
    logic [7:0] data;
} answer_t;

typedef struct packed {
    delay_class_t cls;
    logic [6:0] keys;
} delay_req_t;

endpackage

// ### src/touch_sync.sv
module touch_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

logic [W-1:0] meta;

// first stage feeds the second stage only
always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
        meta <= '0;
        q_o <= '0;
    end else begin
        meta <= d_i;
        q_o <= meta;
    end
end

endmodule

// ### src/touch_link_shift.sv
`include "touch_link_defines.svh"

module touch_link_shift (
    input wire logic sck_i,
    input wire logic ss_n_i,
    input wire logic reset_i,
    input wire logic mosi_i,
    input wire logic [7:0] tx_byte_i,
    output logic [7:0] rx_byte_o,
    output logic rx_toggle_o,
    output logic miso_o
);

logic [6:0] rx_sh;
logic [2:0] in_cnt;
logic [2:0] out_cnt;

////////////////////////////////////////////////////////////////////////////
// receive side, frame cleared by select itself since sck stops between
always_ff @(posedge sck_i or posedge ss_n_i) begin
    if (ss_n_i) begin
        rx_sh <= 7'h00;
        in_cnt <= 3'h0;
    end else begin
        rx_sh <= {rx_sh[5:0], mosi_i};
        in_cnt <= in_cnt + 3'h1;
    end
end

// toggle survives frames; core sees it through two flops
always_ff @(posedge sck_i or posedge reset_i) begin
    if (reset_i) begin
        rx_byte_o <= 8'h00;
        rx_toggle_o <= 1'b0;
    end else if (!ss_n_i && in_cnt == `BIT_LAST) begin
        rx_byte_o <= {rx_sh, mosi_i};
        rx_toggle_o <= ~rx_toggle_o;
    end
end

////////////////////////////////////////////////////////////////////////////
// transmit side: bit 7 stands before the first falling edge
always_ff @(negedge sck_i or posedge ss_n_i) begin
    if (ss_n_i) begin
        out_cnt <= 3'h0;
    end else begin
        out_cnt <= out_cnt + 3'h1;
    end
end

assign miso_o = tx_byte_i[`BIT_LAST - out_cnt];

endmodule

// ### verification/touch_host_model.sv
module touch_host_model (
    input wire logic sck_i,
    input wire logic ss_n_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    input wire logic drdy_n_i,
    output logic sck_o,
    output logic sck_oe_o,
    output logic mosi_o,
    output logic mosi_oe_o,
    output logic ss_n_o,
    output logic ss_n_oe_o,
    output logic [7:0] got_o,
    output int got_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] sh;
    int nb;
    initial begin
        {sck_o, sck_oe_o, mosi_o, mosi_oe_o, ss_n_o, ss_n_oe_o} = 6'h02;
        got_o = 8'h00;
        got_n_o = 0;
        sh = 8'h00;
        nb = 0;
    end
    ////////////////////////////////////////////////////////////////
    // host as master, 6 ns link period; clock runs only inside the frame
    task automatic frame(input logic [7:0] tx, input int nbits, input bit sel,
                         input bit collect, output logic [7:0] rx);
        int i;
        rx = 8'h00;
        {sck_oe_o, mosi_oe_o, ss_n_oe_o} = 3'h7;
        mosi_o = tx[7];
        #20 ss_n_o = !sel;
        #20;
        for (i = 0; i < nbits; i++) begin
            mosi_o = tx[7 - i];
            #3 sck_o = 1'b1;
            rx = {rx[6:0], miso_i};
            #3 sck_o = 1'b0;
        end
        #20;
        // select stays low until the ready line is back high
        for (i = 0; collect && i < 400 && drdy_n_i !== 1'b1; i++) #50;
        if (collect) #2000;
        ss_n_o = 1'b1;
        #20 {sck_oe_o, mosi_oe_o, ss_n_oe_o} = 3'h0;
    endtask
    ////////////////////////////////////////////////////////////////
    // host as slave: take each sensor byte on rising clock
    always @(posedge sck_i or posedge ss_n_i) begin
        if (ss_n_i)
            nb = 0;
        else if (!sck_oe_o) begin
            sh = {sh[6:0], mosi_i};
            nb++;
            if (nb == 8) begin
                got_o = sh;
                got_n_o++;
                nb = 0;
            end
        end
    end
endmodule

// ### verification/touch_link_tb.sv
module touch_link_tb
    import touch_link_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
`define CHK(what, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("BAD %s expected %0h seen %0h", what, exp, got); \
        end \
    end
    // short deadlines keep the run brief
    localparam int T_OTHER = 80;
    localparam int T_CAL = 110;
    localparam int T_ONE = 140;
    localparam int T_EIGHT = 170;
    localparam int T_ALL = 200;
    localparam int T_LOCK = 230;
    localparam delay_class_t cls_tab [6] = '{CLS_OTHER, CLS_CAL, CLS_SETUP, CLS_SETUP,
                                            CLS_SETUP, CLS_LOCK};
    localparam logic [6:0] key_tab [6] = '{7'h00, 7'h00, 7'h01, 7'h08, 7'h09, 7'h00};
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic topology_select_i = 1'b1;
    answer_t answer_i = '0;
    logic answer_valid_i = 1'b0;
    delay_req_t delay_req_i = '0;
    logic cmd_valid_o, answer_ready_o, answer_late_o, master_mode_o, drdy_n_o, miso_o;
    logic [7:0] cmd_byte_o, got, last_cmd;
    logic d_sck, d_sck_oe, d_mosi, d_mosi_oe, d_ss, d_ss_oe;
    logic h_sck, h_sck_oe, h_mosi, h_mosi_oe, h_ss, h_ss_oe;
    logic sck_pin, ss_pin, mosi_pin, prev_late = 1'b0, flt = 1'b0;
    int num_errors = 0, samples_checked = 0, cyc = 0, cmd_n = 0, cmd_at = 0, late_at = 0;
    int got_n;
    always #25 clk_i = ~clk_i;
    // pull-down on clock, pull-up on select, a restless data line when undriven
    assign sck_pin = d_sck_oe ? d_sck : (h_sck_oe ? h_sck : 1'b0);
    assign ss_pin = d_ss_oe ? d_ss : (h_ss_oe ? h_ss : 1'b1);
    assign mosi_pin = d_mosi_oe ? d_mosi : (h_mosi_oe ? h_mosi : flt);
    touch_link #(.T_OTHER(T_OTHER), .T_CAL(T_CAL), .T_ONE(T_ONE), .T_EIGHT(T_EIGHT),
        .T_ALL(T_ALL), .T_LOCK(T_LOCK), .T_SPACE_MAX(400)) DUT (.clk_i(clk_i),
        .reset_i(reset_i), .sck_i(sck_pin), .ss_n_i(ss_pin), .mosi_i(mosi_pin),
        .topology_select_i(topology_select_i), .answer_i(answer_i),
        .answer_valid_i(answer_valid_i), .delay_req_i(delay_req_i),
        .cmd_valid_o(cmd_valid_o), .cmd_byte_o(cmd_byte_o), .answer_ready_o(answer_ready_o),
        .answer_late_o(answer_late_o), .master_mode_o(master_mode_o), .drdy_n_o(drdy_n_o),
        .miso_o(miso_o), .sck_o(d_sck), .sck_oe_o(d_sck_oe), .mosi_o(d_mosi),
        .mosi_oe_o(d_mosi_oe), .ss_n_o(d_ss), .ss_n_oe_o(d_ss_oe));
    touch_host_model host (.sck_i(sck_pin), .ss_n_i(ss_pin), .mosi_i(mosi_pin),
        .miso_i(miso_o), .drdy_n_i(drdy_n_o), .sck_o(h_sck), .sck_oe_o(h_sck_oe),
        .mosi_o(h_mosi), .mosi_oe_o(h_mosi_oe), .ss_n_o(h_ss), .ss_n_oe_o(h_ss_oe),
        .got_o(got), .got_n_o(got_n));
    ////////////////////////////////////////////////////////////////
    always @(negedge clk_i) begin
        cyc++;
        flt <= ~flt;
        if (cmd_valid_o === 1'b1) begin
            cmd_n++;
            cmd_at = cyc;
            last_cmd = cmd_byte_o;
        end
        if (answer_late_o === 1'b1 && prev_late !== 1'b1)
            late_at = cyc;
        prev_late = answer_late_o;
    end
    function automatic int limit(input delay_req_t r);
        case (r.cls)
            CLS_CAL: return T_CAL;
            CLS_SETUP: return r.keys <= 7'h01 ? T_ONE : (r.keys <= 7'h08 ? T_EIGHT : T_ALL);
            CLS_LOCK: return T_LOCK;
            default: return T_OTHER;
        endcase
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic do_reset(input logic topo);
        @(posedge clk_i);
        reset_i <= 1'b1;
        topology_select_i <= topo;
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (10) @(negedge clk_i);
    endtask
    task automatic send_cmd(input logic [7:0] b);
        int n0;
        logic [7:0] rx;
        n0 = cmd_n;
        repeat (1000) @(posedge clk_i);
        host.frame(b, 8, 1'b1, 1'b0, rx);
        while (cmd_n == n0 && cyc - cmd_at < 100000) @(negedge clk_i);
        `CHK("command byte", b, last_cmd)
    endtask
    task automatic give(input logic [7:0] d, input logic echo, input logic last);
        int t0;
        @(posedge clk_i);
        answer_i <= '{echo: echo, last: last, data: d};
        answer_valid_i <= 1'b1;
        @(negedge clk_i);
        t0 = cyc;
        while (answer_ready_o !== 1'b1 && cyc - t0 < 1000) @(negedge clk_i);
        @(posedge clk_i);
        answer_valid_i <= 1'b0;
    endtask
    task automatic read_slave(input logic [7:0] exp);
        int t0;
        logic [7:0] rx;
        t0 = cyc;
        while (drdy_n_o !== 1'b0 && cyc - t0 < 50) @(negedge clk_i);
        `CHK("ready line low", 1'b0, drdy_n_o)
        host.frame(8'h00, 8, 1'b1, 1'b1, rx);
        `CHK("answer byte", exp, rx)
        `CHK("ready line released", 1'b1, drdy_n_o)
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge clk_i);
        num_errors++;
        complete_run();
    end
    initial begin
        int i, j, n, t0, lim;
        logic [7:0] c, d, rx;
        logic ec;
        delay_req_t r;
        n = $urandom(32'h678d0c17);
        do_reset(1'b1);
        `CHK("slave-only mode", 1'b0, master_mode_o)
        `CHK("ready line rest", 1'b1, drdy_n_o)
        host.frame(8'hA5, 8, 1'b0, 1'b0, rx);
        repeat (1000) @(posedge clk_i);
        host.frame(8'h5A, 4, 1'b1, 1'b0, rx);
        repeat (20) @(negedge clk_i);
        `CHK("stray commands", 0, cmd_n)
        `CHK("unasked answer", 1'b0, answer_ready_o)
        $display("test stray done");
        for (i = 0; i < 4; i++) begin
            c = 8'($urandom);
            n = 1 + $urandom % 3;
            send_cmd(c);
            for (j = 0; j < n; j++) begin
                if (j > 0) begin
                    t0 = cyc;
                    while (answer_ready_o !== 1'b1 && cyc - t0 < 1000) @(negedge clk_i);
                    `CHK("byte spacing", 1'b1, cyc - t0 >= 300 && cyc - t0 <= 310)
                    repeat (20) @(negedge clk_i);
                    `CHK("no ready without byte", 1'b1, drdy_n_o)
                end
                d = 8'($urandom);
                ec = (j == n - 1) && i[0];
                give(d, ec, j == n - 1);
                read_slave(ec ? c : d);
            end
            repeat (400) @(negedge clk_i);
            `CHK("quiet after answer", 1'b0, answer_ready_o)
        end
        $display("test slave-only exchange done");
        for (i = 0; i < 6; i++) begin
            r = '{cls: cls_tab[i], keys: key_tab[i]};
            lim = limit(r);
            @(posedge clk_i);
            delay_req_i <= r;
            c = 8'($urandom);
            late_at = 0;
            send_cmd(c);
            t0 = cmd_at;
            repeat (lim + 10) @(negedge clk_i);
            n = late_at - t0;
            `CHK("deadline", 1'b1, n >= lim - 4 && n <= lim + 4)
            `CHK("silent ready line", 1'b1, drdy_n_o)
            if (i == 5) begin
                c = 8'($urandom);
                send_cmd(c);
            end
            give(8'h00, 1'b1, 1'b1);
            read_slave(c);
        end
        $display("test deadlines done");
        do_reset(1'b0);
        `CHK("master-slave mode", 1'b1, master_mode_o)
        c = 8'($urandom);
        send_cmd(c);
        `CHK("quiet while host talks", 3'h0, {d_sck_oe, d_mosi_oe, d_ss_oe})
        for (j = 0; j < 3; j++) begin
            n = got_n;
            d = 8'($urandom);
            give(d, 1'b0, j == 2);
            t0 = cyc;
            while (got_n == n && cyc - t0 < 500) @(negedge clk_i);
            `CHK("sensor sent byte", d, got)
            `CHK("ready line unused", 1'b1, drdy_n_o)
        end
        repeat (40) @(negedge clk_i);
        `CHK("lines released", 3'h0, {d_sck_oe, d_mosi_oe, d_ss_oe})
        $display("test master-slave done");
        complete_run();
    end
endmodule
